// ---- src/gam_top.sv ----
/*
  Global address mapper: control and page registers on a plain register
  port, local-to-global expansion for core and debug accesses, region
  decode, and mirroring of the control register onto the external bus
  in emulation modes.
  Assumes all inputs are synchronous to core_clk and that the external
  bus presents the mirrored control value on extRdData while read.
*/
// Our own choice: the plain strobed port.
//
// Function
// - emulation modes read control register from external bus, else internal.
// - emulation modes also forward control register writes to external bus.
// - bit 7 shows tag RAM and scratch RAM when set.
// - bit 5 shows data flash information sector when set.
// - bit 4 shows program flash information sector when set.
// - high-half select writes once in normal/emulation, anytime in special.
// - select clear maps window 4000-7FFF to external 14_4000-14_7FFF.
// - select set maps window 4000-7FFF to RAM 0F_C000-0F_FFFF.
// - core global instruction uses global page above local address.
// - page index is seven bits, forming a 23-bit global address.
// - debug page applies to firmware global and hardware commands only.
// - debug page above debug address for hardware, core address firmware.
// - program, RAM, storage pages expand core addresses only; debug always uses the debug page.
// - on-chip RAM ends just below 10_0000, sized by parameter.
// - program flash ends just below 80_0000, sized by parameter.
// - expanded modes except emulation single-chip send holes external.
// - external bus active in emulation modes.
`timescale 1ns/1ps
`default_nettype none
module gam_top import gam_pkg::*; #(
  parameter logic [23:0] RAM_BYTES = 24'h00_2000,
  parameter logic [23:0] FLASH_BYTES = 24'h02_0000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [2:0] modeSel,
  input wire logic [7:0] extRdData,
  output logic extWrStrobe,
  output logic extRdStrobe,
  output logic [REG_AW-1:0] extRegAddr,
  output logic [7:0] extWrData,
  output logic extBusActive,
  input wire logic cpuReq,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuGlobal,
  input wire logic dbgFwGlobal,
  input wire logic dbgHwReq,
  input wire logic [15:0] dbgAddr,
  output logic [GADDR_W-1:0] globalAddr,
  output logic globalValid,
  output logic globalFromDebug,
  output gam_region_t globalRegion,
  output logic [7:0] mapCtrlOut
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic ramHighLocked;
    logic [6:0] global_page_index;
    logic [6:0] dpage;
    logic [7:0] program_page_index;
    logic [7:0] ram_page_index;
    logic [7:0] storage_page_index;
    logic [7:0] rdData;
    logic extWr;
    logic extRd;
    logic [REG_AW-1:0] extAddr;
    logic [7:0] extData;
    logic extActive;
    logic [GADDR_W-1:0] gAddr;
    logic gValid;
    logic gDebug;
    gam_region_t region;
  } gam_state_t;

  gam_state_t s_q;
  gam_state_t s_d;
  gam_map_if m ();

  logic emulMode;
  logic specialMode;
  logic ctrlWr;
  logic accReq;
  assign emulMode = modeSel == MODE_ES || modeSel == MODE_EX;
  assign specialMode = modeSel == MODE_SS || modeSel == MODE_ST;
  assign ctrlWr = regWr && regAddr == OFS_MAP_CTRL;
  assign accReq = cpuReq || dbgHwReq;

  // debug hardware command wins: it has no core instruction behind it
  assign m.localAddr = dbgHwReq ? dbgAddr : cpuAddr;
  assign m.useDbgPage = dbgHwReq || (cpuReq && dbgFwGlobal);
  assign m.useGlobalPage = cpuReq && cpuGlobal;
  assign m.globalPage = s_q.global_page_index;
  assign m.dbgPage = s_q.dpage;
  assign m.progPage = s_q.program_page_index;
  assign m.ramPage = s_q.ram_page_index;
  assign m.storPage = s_q.storage_page_index;
  assign m.ramHighHalf = s_q.ctrl[BIT_RAM_HIGH];
  assign m.ctrl = s_q.ctrl;
  assign m.mode = modeSel;

  gam_xlate u_xlate (
    .m(m.xlate)
  );

  gam_decode #(
    .RAM_BYTES(RAM_BYTES),
    .FLASH_BYTES(FLASH_BYTES)
  ) u_decode (
    .m(m.decode)
  );

  always_comb begin
    s_d = s_q;
    s_d.extWr = 1'b0;
    s_d.extRd = 1'b0;
    s_d.rdData = 8'h00;
    if (regWr) begin
      case (regAddr)
        OFS_MAP_CTRL: begin
          s_d.ctrl[BIT_TAG_VIS] = regWrData[BIT_TAG_VIS];
          s_d.ctrl[BIT_DINFO_VIS] = regWrData[BIT_DINFO_VIS];
          s_d.ctrl[BIT_PINFO_VIS] = regWrData[BIT_PINFO_VIS];
          if (specialMode || !s_q.ramHighLocked) begin
            s_d.ctrl[BIT_RAM_HIGH] = regWrData[BIT_RAM_HIGH];
          end
          // lock clears only through rst
          if (!specialMode) begin
            s_d.ramHighLocked = 1'b1;
          end
          if (emulMode) begin
            s_d.extWr = 1'b1;
            s_d.extAddr = regAddr;
            s_d.extData = regWrData;
          end
        end
        OFS_GLOBAL_PAGE: s_d.global_page_index = regWrData[6:0];
        OFS_DEBUG_PAGE: s_d.dpage = regWrData[6:0];
        OFS_PROG_PAGE: s_d.program_page_index = regWrData;
        OFS_RAM_PAGE: s_d.ram_page_index = regWrData;
        OFS_STOR_PAGE: s_d.storage_page_index = regWrData;
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFS_MAP_CTRL: begin
          if (emulMode) begin
            s_d.rdData = extRdData;
            s_d.extRd = 1'b1;
            s_d.extAddr = regAddr;
          end else begin
            s_d.rdData = s_q.ctrl & CTRL_RW_MASK;
          end
        end
        OFS_GLOBAL_PAGE: s_d.rdData = {1'b0, s_q.global_page_index};
        OFS_DEBUG_PAGE: s_d.rdData = {1'b0, s_q.dpage};
        OFS_PROG_PAGE: s_d.rdData = s_q.program_page_index;
        OFS_RAM_PAGE: s_d.rdData = s_q.ram_page_index;
        OFS_STOR_PAGE: s_d.rdData = s_q.storage_page_index;
        default: s_d.rdData = 8'h00;
      endcase
    end
    s_d.extActive = emulMode || modeSel == MODE_NX
      || modeSel == MODE_ST;
    s_d.gValid = accReq;
    s_d.gDebug = dbgHwReq;
    if (accReq) begin
      s_d.gAddr = m.globalAddr;
      s_d.region = m.region;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '{ctrl: CTRL_RESET, ramHighLocked: 1'b0, global_page_index: GLOBAL_PAGE_INDEX_RESET,
        dpage: GLOBAL_PAGE_INDEX_RESET, program_page_index: PAGE_RESET, ram_page_index: PAGE_RESET,
        storage_page_index: PAGE_RESET, rdData: 8'h00, extWr: 1'b0, extRd: 1'b0,
        extAddr: 8'h00, extData: 8'h00, extActive: 1'b0,
        gAddr: 23'h00_0000, gValid: 1'b0, gDebug: 1'b0,
        region: RGN_NONE};
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign extWrStrobe = s_q.extWr;
  assign extRdStrobe = s_q.extRd;
  assign extRegAddr = s_q.extAddr;
  assign extWrData = s_q.extData;
  assign extBusActive = s_q.extActive;
  assign globalAddr = s_q.gAddr;
  assign globalValid = s_q.gValid;
  assign globalFromDebug = s_q.gDebug;
  assign globalRegion = s_q.region;
  // bits 6,2,1,0 are never loaded, so the register needs no mask here
  assign mapCtrlOut = s_q.ctrl;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic inHalf;
  assign inHalf = cpuAddr >= WIN_HALF_LO && cpuAddr <= WIN_HALF_HI;

  property p_emul_read;
    regRd && regAddr == OFS_MAP_CTRL && emulMode
      |=> regRdData == $past(extRdData) && extRdStrobe;
  endproperty
  a_emul_read: assert property (p_emul_read)
    else $error("emulation read not taken from external bus");

  property p_plain_read;
    regRd && regAddr == OFS_MAP_CTRL && !emulMode
      |=> regRdData == mapCtrlOut && !extRdStrobe;
  endproperty
  a_plain_read: assert property (p_plain_read)
    else $error("control read does not show internal value");

  property p_mirror_write;
    ctrlWr && emulMode |=> extWrStrobe && extWrData == $past(regWrData)
      && extRegAddr == OFS_MAP_CTRL
      ##1 extWrStrobe == $past(ctrlWr && emulMode);
  endproperty
  a_mirror_write: assert property (p_mirror_write)
    else $error("emulation write not mirrored for one cycle");

  property p_tag_vis;
    ctrlWr |=> mapCtrlOut[BIT_TAG_VIS] == $past(regWrData[BIT_TAG_VIS]);
  endproperty
  a_tag_vis: assert property (p_tag_vis)
    else $error("tag visibility bit not written");

  property p_info_vis;
    ctrlWr |=> mapCtrlOut[BIT_DINFO_VIS] == $past(regWrData[BIT_DINFO_VIS])
      && mapCtrlOut[BIT_PINFO_VIS] == $past(regWrData[BIT_PINFO_VIS]);
  endproperty
  a_info_vis: assert property (p_info_vis)
    else $error("information sector bits not written");

  property p_write_once;
    ctrlWr && !specialMode && s_q.ramHighLocked
      |=> $stable(mapCtrlOut[BIT_RAM_HIGH]);
  endproperty
  a_write_once: assert property (p_write_once)
    else $error("high-half select changed on second write");

  property p_special_write;
    ctrlWr && specialMode
      |=> mapCtrlOut[BIT_RAM_HIGH] == $past(regWrData[BIT_RAM_HIGH]);
  endproperty
  a_special_write: assert property (p_special_write)
    else $error("special mode write to high-half select lost");

  property p_half_ext;
    cpuReq && !cpuGlobal && !dbgFwGlobal && !dbgHwReq && inHalf
      && !mapCtrlOut[BIT_RAM_HIGH] && !ctrlWr
      |=> globalAddr == HALF_EXT_BASE + {9'h000, $past(cpuAddr[13:0])};
  endproperty
  a_half_ext: assert property (p_half_ext)
    else $error("window not mapped to external half");

  property p_half_ram;
    cpuReq && !cpuGlobal && !dbgFwGlobal && !dbgHwReq && inHalf
      && mapCtrlOut[BIT_RAM_HIGH] && !ctrlWr
      |=> globalAddr == HALF_RAM_BASE + {9'h000, $past(cpuAddr[13:0])}
      && (globalRegion == RGN_RAM
      || {1'b0, globalAddr} < RAM_TOP - RAM_BYTES);
  endproperty
  a_half_ram: assert property (p_half_ram)
    else $error("window not mapped into RAM");

  property p_global_page;
    cpuReq && cpuGlobal && !dbgFwGlobal && !dbgHwReq
      |=> globalValid && globalAddr == {$past(s_q.global_page_index), $past(cpuAddr)};
  endproperty
  a_global_page: assert property (p_global_page)
    else $error("global instruction address wrong");

  property p_debug_hw;
    dbgHwReq |=> globalFromDebug
      && globalAddr == {$past(s_q.dpage), $past(dbgAddr)};
  endproperty
  a_debug_hw: assert property (p_debug_hw)
    else $error("debug hardware address wrong");

  property p_ram_region;
    globalValid && {1'b0, globalAddr} >= RAM_TOP - RAM_BYTES
      && {1'b0, globalAddr} < RAM_TOP |-> globalRegion == RGN_RAM;
  endproperty
  a_ram_region: assert property (p_ram_region)
    else $error("RAM range not decoded as RAM");

  property p_ext_active;
    emulMode |=> extBusActive;
  endproperty
  a_ext_active: assert property (p_ext_active)
    else $error("external bus idle in emulation mode");

  property p_lock_arm;
    ctrlWr && !specialMode |=> s_q.ramHighLocked;
  endproperty
  a_lock_arm: assert property (p_lock_arm)
    else $error("high-half lock not armed by write");

  property p_debug_fw;
    cpuReq && dbgFwGlobal && !dbgHwReq |=> !globalFromDebug
      && globalAddr == {$past(s_q.dpage), $past(cpuAddr)};
  endproperty
  a_debug_fw: assert property (p_debug_fw)
    else $error("firmware global address wrong");

  // flash top is the map top, so only the low bound needs checking
  property p_flash_region;
    globalValid && {1'b0, globalAddr} >= FLASH_TOP - FLASH_BYTES
      |-> globalRegion == RGN_FLASH;
  endproperty
  a_flash_region: assert property (p_flash_region)
    else $error("flash range not decoded as flash");

  property p_ext_route;
    globalValid && globalRegion == RGN_EXT |-> $past(modeSel == MODE_NX
      || modeSel == MODE_EX || modeSel == MODE_ST);
  endproperty
  a_ext_route: assert property (p_ext_route)
    else $error("hole routed external outside expanded modes");

  property p_hidden_regions;
    globalValid
      |-> (globalRegion != RGN_TAG || $past(mapCtrlOut[BIT_TAG_VIS]))
      && (globalRegion != RGN_DINFO || $past(mapCtrlOut[BIT_DINFO_VIS]))
      && (globalRegion != RGN_PINFO || $past(mapCtrlOut[BIT_PINFO_VIS]));
  endproperty
  a_hidden_regions: assert property (p_hidden_regions)
    else $error("hidden region decoded while its bit is clear");

  property p_read_idle;
    !regRd |=> regRdData == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data present without a read");

  c_emul_mirror: cover property (ctrlWr && emulMode ##1 extWrStrobe);
  c_locked_write: cover property (ctrlWr && !specialMode
    ##[1:4] ctrlWr && !specialMode);
  c_debug_fw: cover property (cpuReq && dbgFwGlobal && !dbgHwReq);
  c_ext_region: cover property (globalValid && globalRegion == RGN_EXT);
  c_pinfo_region: cover property (globalValid && globalRegion == RGN_PINFO);
endmodule
`default_nettype wire

// ---- shared/gam_pkg.sv ----
/*
  Constants and types for the global address mapper: register offsets,
  control bit positions, operating mode codes, local windows, global
  region bounds.
  Assumes an 8-bit register port and a 23-bit global address space.
*/
`default_nettype none
package gam_pkg;
  localparam int REG_AW = 8;
  localparam int GADDR_W = 23;

  // register offsets
  localparam logic [7:0] OFS_MAP_CTRL = 8'h13;
  localparam logic [7:0] OFS_GLOBAL_PAGE = 8'h10;
  localparam logic [7:0] OFS_DEBUG_PAGE = 8'h11;
  localparam logic [7:0] OFS_PROG_PAGE = 8'h15;
  localparam logic [7:0] OFS_RAM_PAGE = 8'h16;
  localparam logic [7:0] OFS_STOR_PAGE = 8'h17;

  // control bit positions and reset values
  localparam int BIT_TAG_VIS = 7;
  localparam int BIT_DINFO_VIS = 5;
  localparam int BIT_PINFO_VIS = 4;
  localparam int BIT_RAM_HIGH = 3;
  localparam logic [7:0] CTRL_RW_MASK = 8'hB8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [6:0] GLOBAL_PAGE_INDEX_RESET = 7'h00;

  // operating modes
  localparam logic [2:0] MODE_NS = 3'h0;
  localparam logic [2:0] MODE_SS = 3'h1;
  localparam logic [2:0] MODE_NX = 3'h2;
  localparam logic [2:0] MODE_ES = 3'h3;
  localparam logic [2:0] MODE_EX = 3'h4;
  localparam logic [2:0] MODE_ST = 3'h5;

  // local windows
  localparam logic [15:0] WIN_HALF_LO = 16'h4000;
  localparam logic [15:0] WIN_HALF_HI = 16'h7FFF;
  localparam logic [15:0] WIN_PROG_LO = 16'h8000;
  localparam logic [15:0] WIN_PROG_HI = 16'hBFFF;
  localparam logic [15:0] WIN_RAM_LO = 16'h1000;
  localparam logic [15:0] WIN_RAM_HI = 16'h1FFF;
  localparam logic [15:0] WIN_STOR_LO = 16'h0800;
  localparam logic [15:0] WIN_STOR_HI = 16'h0FFF;

  // global bases
  localparam logic [22:0] HALF_EXT_BASE = 23'h14_4000;
  localparam logic [22:0] HALF_RAM_BASE = 23'h0F_C000;
  localparam logic [22:0] PROG_BASE = 23'h40_0000;
  localparam logic [22:0] RAM_PAGE_INDEX_BASE = 23'h00_0000;
  localparam logic [22:0] STORAGE_PAGE_INDEX_BASE = 23'h10_0000;
  localparam logic [22:0] DIRECT_BASE = 23'h7F_0000;

  // global region bounds, 24 bits so the flash top fits
  localparam logic [23:0] RAM_TOP = 24'h10_0000;
  localparam logic [23:0] FLASH_TOP = 24'h80_0000;
  localparam logic [23:0] TAG_LO = 24'h0C_0000;
  localparam logic [23:0] TAG_HI = 24'h0C_0FFF;
  localparam logic [23:0] DINFO_LO = 24'h10_4000;
  localparam logic [23:0] DINFO_HI = 24'h10_43FF;
  localparam logic [23:0] PINFO_LO = 24'h40_4000;
  localparam logic [23:0] PINFO_HI = 24'h40_43FF;

  typedef enum logic [2:0] {
    RGN_NONE, RGN_RAM, RGN_FLASH, RGN_TAG, RGN_DINFO, RGN_PINFO, RGN_EXT
  } gam_region_t;
endpackage
`default_nettype wire

// ---- shared/gam_map_if.sv ----
/*
  Bundle between the mapper top, its address translator and its region
  decoder.
  Assumes the top drives the request side and the page registers.
*/
`timescale 1ns/1ps
`default_nettype none
interface gam_map_if;
  import gam_pkg::*;
  logic [15:0] localAddr;
  logic useDbgPage;
  logic useGlobalPage;
  logic [6:0] globalPage;
  logic [6:0] dbgPage;
  logic [7:0] progPage;
  logic [7:0] ramPage;
  logic [7:0] storPage;
  logic ramHighHalf;
  logic [7:0] ctrl;
  logic [2:0] mode;
  logic [22:0] globalAddr;
  gam_region_t region;
  modport top (output localAddr, useDbgPage, useGlobalPage, globalPage,
    dbgPage, progPage, ramPage, storPage, ramHighHalf, ctrl, mode,
    input globalAddr, region);
  modport xlate (input localAddr, useDbgPage, useGlobalPage, globalPage,
    dbgPage, progPage, ramPage, storPage, ramHighHalf,
    output globalAddr);
  modport decode (input globalAddr, ctrl, mode, output region);
endinterface
`default_nettype wire

// ---- src/gam_xlate.sv ----
/*
  Local to global address translation, purely combinational.
  Assumes the top has already chosen the local address and page source.
*/
`timescale 1ns/1ps
`default_nettype none
module gam_xlate import gam_pkg::*; (
  gam_map_if.xlate m
);
  logic [15:0] a;
  assign a = m.localAddr;

  always_comb begin
    if (m.useDbgPage) begin
      m.globalAddr = {m.dbgPage, a};
    end else if (m.useGlobalPage) begin
      m.globalAddr = {m.globalPage, a};
    end else if (a >= WIN_HALF_LO && a <= WIN_HALF_HI) begin
      m.globalAddr = (m.ramHighHalf ? HALF_RAM_BASE : HALF_EXT_BASE)
        + {9'h000, a[13:0]};
    end else if (a >= WIN_PROG_LO && a <= WIN_PROG_HI) begin
      m.globalAddr = PROG_BASE + {1'b0, m.progPage, a[13:0]};
    end else if (a >= WIN_RAM_LO && a <= WIN_RAM_HI) begin
      m.globalAddr = RAM_PAGE_INDEX_BASE + {3'h0, m.ramPage, a[11:0]};
    end else if (a >= WIN_STOR_LO && a <= WIN_STOR_HI) begin
      m.globalAddr = STORAGE_PAGE_INDEX_BASE + {5'h00, m.storPage, a[9:0]};
    end else begin
      m.globalAddr = DIRECT_BASE + {7'h00, a};
    end
  end
endmodule
`default_nettype wire

// ---- src/gam_decode.sv ----
/*
  Classifies a global address into the resource that serves it.
  Assumes on-chip sizes are fixed at build time by parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module gam_decode import gam_pkg::*; #(
  parameter logic [23:0] RAM_BYTES = 24'h00_2000,
  parameter logic [23:0] FLASH_BYTES = 24'h02_0000
) (
  gam_map_if.decode m
);
  logic [23:0] ga;
  logic extOk;
  assign ga = {1'b0, m.globalAddr};
  // emulation single-chip is expanded but keeps holes off the bus
  assign extOk = m.mode == MODE_NX || m.mode == MODE_EX
    || m.mode == MODE_ST;

  always_comb begin
    if (ga >= RAM_TOP - RAM_BYTES && ga < RAM_TOP) begin
      m.region = RGN_RAM;
    end else if (ga >= FLASH_TOP - FLASH_BYTES && ga < FLASH_TOP) begin
      m.region = RGN_FLASH;
    end else if (m.ctrl[BIT_TAG_VIS] && ga >= TAG_LO && ga <= TAG_HI) begin
      m.region = RGN_TAG;
    end else if (m.ctrl[BIT_DINFO_VIS] && ga >= DINFO_LO
        && ga <= DINFO_HI) begin
      m.region = RGN_DINFO;
    end else if (m.ctrl[BIT_PINFO_VIS] && ga >= PINFO_LO
        && ga <= PINFO_HI) begin
      m.region = RGN_PINFO;
    end else if (extOk) begin
      m.region = RGN_EXT;
    end else begin
      m.region = RGN_NONE;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/gam_ext_model.sv ----
/*
  Behavioural emulation tool on the external bus: keeps its own copy of
  the mirrored control register and presents it for mirrored reads.
  Assumes the mapper strobes writes one cycle after the register write.
*/
`timescale 1ns/1ps
`default_nettype none
module gam_ext_model import gam_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic extWrStrobe,
  input wire logic [REG_AW-1:0] extRegAddr,
  input wire logic [7:0] extWrData,
  output logic [7:0] extRdData
);
  logic [7:0] mirror_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mirror_q <= 8'h00;
    end else if (extWrStrobe && extRegAddr == OFS_MAP_CTRL) begin
      mirror_q <= extWrData;
    end
  end
  // full byte kept, so a mirrored read differs from the masked register
  assign extRdData = mirror_q;
endmodule
`default_nettype wire

// ---- testbench/tb_global_address_mapper.sv ----
/*
  Self-checking bench for the mapper: register port tasks, access tasks
  and sequences of calls with expected values.
  Assumes the external tool model answers mirrored control reads.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_global_address_mapper import gam_pkg::*;;
  logic core_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [REG_AW-1:0] regAddr = 8'h00, extRegAddr;
  logic [7:0] regWrData = 8'h00, regRdData, extRdData, extWrData, mapCtrlOut;
  logic [2:0] modeSel = MODE_NS;
  logic extWrStrobe, extRdStrobe, extBusActive, globalValid, globalFromDebug;
  logic cpuReq = 1'b0, cpuGlobal = 1'b0, dbgFwGlobal = 1'b0, dbgHwReq = 1'b0;
  logic [15:0] cpuAddr = 16'h0000, dbgAddr = 16'h0000;
  logic [GADDR_W-1:0] globalAddr;
  gam_region_t globalRegion;
  int err_count = 0, n_tests = 0;
  logic [7:0] rdv;

  // RAM sized so the high-half window lands exactly on its low end
  gam_top #(.RAM_BYTES(24'h00_4000), .FLASH_BYTES(24'h02_0000)) DUT (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .modeSel(modeSel), .extRdData(extRdData),
    .extWrStrobe(extWrStrobe), .extRdStrobe(extRdStrobe),
    .extRegAddr(extRegAddr), .extWrData(extWrData),
    .extBusActive(extBusActive), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
    .cpuGlobal(cpuGlobal), .dbgFwGlobal(dbgFwGlobal), .dbgHwReq(dbgHwReq),
    .dbgAddr(dbgAddr), .globalAddr(globalAddr), .globalValid(globalValid),
    .globalFromDebug(globalFromDebug), .globalRegion(globalRegion),
    .mapCtrlOut(mapCtrlOut));
  gam_ext_model TOOL (.core_clk(core_clk), .rst(rst),
    .extWrStrobe(extWrStrobe), .extRegAddr(extRegAddr),
    .extWrData(extWrData), .extRdData(extRdData));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge core_clk);
    rst <= 1'b1;
    modeSel <= m;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic acc(input logic cr, input logic g, input logic fw,
    input logic hw, input logic [15:0] ca, input logic [15:0] da,
    input logic [22:0] ea, input gam_region_t er);
    @(posedge core_clk);
    cpuReq <= cr;
    cpuGlobal <= g;
    dbgFwGlobal <= fw;
    dbgHwReq <= hw;
    cpuAddr <= ca;
    dbgAddr <= da;
    @(posedge core_clk);
    cpuReq <= 1'b0;
    dbgHwReq <= 1'b0;
    #1;
    `CHK(globalValid, 1'b1)
    `CHK(globalAddr, ea)
    `CHK(globalRegion, er)
    `CHK(globalFromDebug, hw)
  endtask

  initial begin
    #(25 * 5000);
    err_count++;
    report_and_stop();
  end

  initial begin
    do_reset(MODE_NS);
    rd(OFS_MAP_CTRL, rdv);
    `CHK(rdv, CTRL_RESET)
    rd(8'h00, rdv);
    `CHK(rdv, 8'h00)
    // bus activity in all modes except normal and special single-chip
    for (int m = 0; m < 6; m++) begin
      @(posedge core_clk);
      modeSel <= 3'(m);
      repeat (2) @(posedge core_clk);
      #1 `CHK(extBusActive, 1'(m >= 2))
    end
    do_reset(MODE_NX);
    acc(1, 0, 0, 0, 16'h4123, 16'h0, 23'h14_4123, RGN_EXT);
    wr(OFS_MAP_CTRL, 8'hFF);
    `CHK(mapCtrlOut, CTRL_RW_MASK)
    `CHK(extWrStrobe, 1'b0)
    wr(OFS_MAP_CTRL, 8'h00);
    `CHK(mapCtrlOut, 8'h08)
    acc(1, 0, 0, 0, 16'h4123, 16'h0, 23'h0F_C123, RGN_RAM);
    rd(OFS_MAP_CTRL, rdv);
    `CHK(rdv, 8'h08)
    `CHK(extRdStrobe, 1'b0)
    // ram page window around the low and top ends of the RAM
    wr(OFS_RAM_PAGE, 8'hFB);
    acc(1, 0, 0, 0, 16'h1FFF, 16'h0, 23'h0F_BFFF, RGN_EXT);
    wr(OFS_RAM_PAGE, 8'hFF);
    acc(1, 0, 0, 0, 16'h1FFF, 16'h0, 23'h0F_FFFF, RGN_RAM);
    wr(OFS_STOR_PAGE, 8'h00);
    acc(1, 0, 0, 0, 16'h0800, 16'h0, 23'h10_0000, RGN_EXT);
    // global page: flash bounds
    wr(OFS_GLOBAL_PAGE, 8'hFF);
    rd(OFS_GLOBAL_PAGE, rdv);
    `CHK(rdv, 8'h7F)
    acc(1, 1, 0, 0, 16'hFFFF, 16'h0, 23'h7F_FFFF, RGN_FLASH);
    wr(OFS_GLOBAL_PAGE, 8'h7E);
    acc(1, 1, 0, 0, 16'h0000, 16'h0, 23'h7E_0000, RGN_FLASH);
    wr(OFS_GLOBAL_PAGE, 8'h7D);
    acc(1, 1, 0, 0, 16'hFFFF, 16'h0, 23'h7D_FFFF, RGN_EXT);
    acc(1, 0, 0, 0, 16'h2000, 16'h0, 23'h7F_2000, RGN_FLASH);
    // debug page: hardware and firmware commands only
    wr(OFS_DEBUG_PAGE, 8'h12);
    acc(0, 0, 0, 1, 16'h0, 16'h3456, 23'h12_3456, RGN_EXT);
    acc(1, 0, 1, 0, 16'h0101, 16'h3456, 23'h12_0101, RGN_EXT);
    acc(1, 1, 0, 0, 16'h0101, 16'h3456, 23'h7D_0101, RGN_EXT);
    // page registers reachable for read and write
    wr(OFS_PROG_PAGE, 8'hF8);
    rd(OFS_PROG_PAGE, rdv);
    `CHK(rdv, 8'hF8)
    wr(OFS_STOR_PAGE, 8'h5C);
    rd(OFS_STOR_PAGE, rdv);
    `CHK(rdv, 8'h5C)
    acc(1, 0, 0, 0, 16'h8123, 16'h0, 23'h7E_0123, RGN_FLASH);
    // visibility bits, each shown then hidden again
    for (int i = 0; i < 3; i++) begin
      logic [7:0] msk;
      logic [7:0] pg;
      gam_region_t rg;
      msk = (i == 0) ? 8'h80 : (i == 1) ? 8'h20 : 8'h10;
      pg = (i == 0) ? 8'h0C : (i == 1) ? 8'h10 : 8'h40;
      rg = (i == 0) ? RGN_TAG : (i == 1) ? RGN_DINFO : RGN_PINFO;
      wr(OFS_GLOBAL_PAGE, pg);
      wr(OFS_MAP_CTRL, msk);
      `CHK(mapCtrlOut, msk | 8'h08)
      acc(1, 1, 0, 0, 16'h4000 & {16{i != 0}}, 16'h0,
        {pg[6:0], 16'h4000 & {16{i != 0}}}, rg);
      wr(OFS_MAP_CTRL, 8'h00);
      acc(1, 1, 0, 0, 16'h4000 & {16{i != 0}}, 16'h0,
        {pg[6:0], 16'h4000 & {16{i != 0}}}, RGN_EXT);
    end
    // special mode: select writable any number of times
    do_reset(MODE_SS);
    wr(OFS_MAP_CTRL, 8'h08);
    wr(OFS_MAP_CTRL, 8'h00);
    `CHK(mapCtrlOut, 8'h00)
    wr(OFS_MAP_CTRL, 8'h08);
    `CHK(mapCtrlOut, 8'h08)
    // lock cleared by reset only
    do_reset(MODE_NX);
    wr(OFS_MAP_CTRL, 8'h08);
    `CHK(mapCtrlOut, 8'h08)
    // emulation: writes mirrored, reads served by the tool
    do_reset(MODE_ES);
    wr(OFS_MAP_CTRL, 8'hA5);
    `CHK(extWrStrobe, 1'b1)
    `CHK(extWrData, 8'hA5)
    `CHK(extRegAddr, OFS_MAP_CTRL)
    `CHK(mapCtrlOut, 8'hA0)
    rd(OFS_MAP_CTRL, rdv);
    `CHK(rdv, 8'hA5)
    `CHK(extRdStrobe, 1'b1)
    acc(1, 0, 0, 0, 16'h4123, 16'h0, 23'h14_4123, RGN_NONE);
    wr(OFS_MAP_CTRL, 8'h08);
    `CHK(mapCtrlOut, 8'h00)
    @(posedge core_clk);
    modeSel <= MODE_EX;
    wr(OFS_MAP_CTRL, 8'h3C);
    `CHK(extWrStrobe, 1'b1)
    rd(OFS_MAP_CTRL, rdv);
    `CHK(rdv, 8'h3C)
    @(posedge core_clk);
    modeSel <= MODE_NX;
    rd(OFS_MAP_CTRL, rdv);
    `CHK(rdv, 8'h30)
    report_and_stop();
  end
endmodule
`default_nettype wire
